// ---- logic/psd_pkg.sv ----
// Purpose: shared constants and codes for the strap configuration decoder
// Assumes: 50 MHz system clock
// Notes: codes below are the decoder's own output encodings
package psd_pkg;

	localparam int unsigned CLK_PERIOD_PS = 20000;
	// weak pull settling time per sampling phase
	localparam int unsigned SETTLE_NS = 1000;
	localparam int unsigned SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// line rate thresholds in Mbps
	localparam int unsigned RATE_HI_MBPS = 3400;
	localparam int unsigned RATE_LO_MBPS = 2000;
	localparam int unsigned RATE_W = 14;

	// three-level straps, index into the strap vector
	localparam int unsigned NUM_STRAPS = 5;
	localparam int unsigned IDX_EDGE = 0;
	localparam int unsigned IDX_DEEMPH = 1;
	localparam int unsigned IDX_EQ = 2;
	localparam int unsigned IDX_TERM = 3;
	localparam int unsigned IDX_SWAP = 4;

	// reset values
	localparam logic RST_OP_ENABLE = 1'b1;
	localparam logic RST_POWER_DOWN = 1'b1;

	typedef enum logic [1:0] {PSD_LVL_LOW = 2'h0, PSD_LVL_HIGH = 2'h1, PSD_LVL_FLOAT = 2'h2} psd_level_t;
	typedef enum logic [1:0] {PSD_EDGE_FAST = 2'h0, PSD_EDGE_SLOW5 = 2'h1, PSD_EDGE_SLOW10 = 2'h2} psd_edge_t;
	typedef enum logic [1:0] {PSD_DE_0DB = 2'h0, PSD_DE_M2DB = 2'h1, PSD_DE_RSVD = 2'h2} psd_deemph_t;
	typedef enum logic [1:0] {PSD_EQ_FIX7P5 = 2'h0, PSD_EQ_ADAPT = 2'h1, PSD_EQ_FIX14 = 2'h2} psd_eq_t;
	typedef enum logic [1:0] {PSD_TERM_NONE = 2'h0, PSD_TERM_75_150 = 2'h1, PSD_TERM_150_300 = 2'h2,
		PSD_TERM_AUTO = 2'h3} psd_term_t;
	typedef enum logic [1:0] {PSD_LANE_NORMAL = 2'h0, PSD_LANE_SWAP = 2'h1, PSD_LANE_POLINV = 2'h2} psd_lane_t;
	// gray along pull-up -> pull-down -> done
	typedef enum logic [1:0] {PSD_ST_PULLUP = 2'h0, PSD_ST_PULLDN = 2'h1, PSD_ST_DONE = 2'h3} psd_state_t;

endpackage

// ---- logic/psd_strap_decoder.sv ----
// Purpose: control-pin and strap decoder of a retimer, strap mode versus serial-control mode
// Assumes: strap pins and mode pins are asynchronous; bus_* settings come from a register block on sys_clk
// Notes: straps are sensed once per reset with weak pulls; results hold until the next reset
// Operation
// - a low operation-enable input puts the device into power-down, a high one lets it run.
// - a falling operation-enable input resets the device; its weak pull-up means undriven runs normally.
// - mode select high takes configuration from the control bus, low takes it from the straps.
// - in strap mode the straps win and control-bus settings cannot alter strap functions.
// - edge-rate strap high is fastest, low is 5 ps slower, open is 10 ps slower.
// - in serial-control mode the edge rate comes from the bus-programmed value.
// - de-emphasis strap low gives -2 dB, open gives 0 dB, high is reserved.
// - equalizer strap low is fixed 7.5 dB, open is adaptive, high is fixed 14 dB.
// - in serial-control mode the equalizer pin is a two-level address bit 1.
// - video-mode strap high selects DVI, low selects the adaptor-ID video mode.
// - in serial-control mode the video-mode pin is address bit 2 with a weak pull-down.
// - termination strap high is none, low is 75-150 ohm, open selects automatic termination.
// - automatic termination gives 75-150 ohm above 3.4 Gbps, 150-300 between 2 and 3.4, none below 2.
// - lane strap high inverts receive polarity, low swaps lanes, open leaves lanes unchanged.
`timescale 1ns/1ps

module psd_strap_decoder #(
	parameter int unsigned SETTLE_CYCLES = psd_pkg::SETTLE_CYC,
	parameter int unsigned LINE_RATE_W = psd_pkg::RATE_W
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic op_enable,
	input wire logic control_mode_sel,
	input wire logic edge_rate_strap,
	input wire logic deemph_strap,
	input wire logic equalizer_strap_addr1,
	input wire logic termination_strap,
	input wire logic lane_swap_polarity_strap,
	input wire logic video_mode_strap_addr2,
	input wire logic [LINE_RATE_W-1:0] line_rate,
	input wire psd_pkg::psd_edge_t bus_edge_rate,
	input wire psd_pkg::psd_deemph_t bus_deemph,
	input wire psd_pkg::psd_eq_t bus_eq,
	input wire psd_pkg::psd_term_t bus_term,
	input wire psd_pkg::psd_lane_t bus_lane,
	input wire logic bus_video_dvi,
	output logic [psd_pkg::NUM_STRAPS-1:0] strap_pull_up_en,
	output logic [psd_pkg::NUM_STRAPS-1:0] strap_pull_dn_en,
	output logic video_pull_dn_en,
	output logic op_pull_up_en,
	output logic power_down,
	output logic device_reset,
	output logic strap_mode,
	output logic config_valid,
	output psd_pkg::psd_edge_t edge_rate_sel,
	output psd_pkg::psd_deemph_t deemph_sel,
	output psd_pkg::psd_eq_t eq_sel,
	output psd_pkg::psd_term_t term_sel,
	output logic term_auto,
	output psd_pkg::psd_lane_t lane_sel,
	output logic video_dvi,
	output logic [1:0] bus_addr_bits
);

	localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);
	localparam int unsigned NSYNC = psd_pkg::NUM_STRAPS + 3;

	if (SETTLE_CYCLES < 1)
		$error("SETTLE_CYCLES must be at least one");
	if ((2 ** LINE_RATE_W) <= psd_pkg::RATE_HI_MBPS)
		$error("LINE_RATE_W too narrow for the rate thresholds");

	localparam logic [LINE_RATE_W-1:0] RATE_HI = LINE_RATE_W'(psd_pkg::RATE_HI_MBPS);
	localparam logic [LINE_RATE_W-1:0] RATE_LO = LINE_RATE_W'(psd_pkg::RATE_LO_MBPS);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

	function automatic psd_pkg::psd_level_t resolve_level(input logic under_up, input logic under_dn);
		psd_pkg::psd_level_t lvl;
		lvl = psd_pkg::PSD_LVL_FLOAT;
		if (under_up && under_dn)
			lvl = psd_pkg::PSD_LVL_HIGH;
		else if (!under_up && !under_dn)
			lvl = psd_pkg::PSD_LVL_LOW;
		return lvl;
	endfunction

	function automatic psd_pkg::psd_term_t auto_term(input logic [LINE_RATE_W-1:0] rate);
		psd_pkg::psd_term_t t;
		t = psd_pkg::PSD_TERM_NONE;
		if (rate > RATE_HI)
			t = psd_pkg::PSD_TERM_75_150;
		else if (rate >= RATE_LO)
			t = psd_pkg::PSD_TERM_150_300;
		return t;
	endfunction

	// two-stage synchroniser for every pin
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	assign pin_raw = {video_mode_strap_addr2, control_mode_sel, op_enable, lane_swap_polarity_strap,
		termination_strap, equalizer_strap_addr1, deemph_strap, edge_rate_strap};

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sync_a <= {1'b0, 1'b0, psd_pkg::RST_OP_ENABLE, {psd_pkg::NUM_STRAPS{1'b0}}};
			sync_b <= {1'b0, 1'b0, psd_pkg::RST_OP_ENABLE, {psd_pkg::NUM_STRAPS{1'b0}}};
		end
		else
		begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
		end
	end

	logic [psd_pkg::NUM_STRAPS-1:0] strap_s;
	logic op_s;
	logic mode_s;
	logic video_s;
	assign strap_s = sync_b[psd_pkg::NUM_STRAPS-1:0];
	assign op_s = sync_b[psd_pkg::NUM_STRAPS];
	assign mode_s = sync_b[psd_pkg::NUM_STRAPS+1];
	assign video_s = sync_b[psd_pkg::NUM_STRAPS+2];

	logic op_prev;
	logic op_fall;
	assign op_fall = op_prev && !op_s;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			op_prev <= psd_pkg::RST_OP_ENABLE;
		else
			op_prev <= op_s;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			device_reset <= 1'b1;
		else
			device_reset <= op_fall;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			power_down <= psd_pkg::RST_POWER_DOWN;
		else
			power_down <= !op_s;
	end

	// sensing sequencer
	psd_pkg::psd_state_t state;
	logic [CNT_W-1:0] settle_cnt;
	logic phase_end;
	assign phase_end = (settle_cnt == SETTLE_LAST);

	// re-sense after reset or enable fall, then hold
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= psd_pkg::PSD_ST_PULLUP;
			settle_cnt <= '0;
		end
		else if (op_fall || !op_s)
		begin
			state <= psd_pkg::PSD_ST_PULLUP;
			settle_cnt <= '0;
		end
		else
		begin
			unique case (state)
				psd_pkg::PSD_ST_PULLUP,
				psd_pkg::PSD_ST_PULLDN:
				begin
					settle_cnt <= phase_end ? '0 : settle_cnt + CNT_W'(1);
					if (phase_end)
						state <= (state == psd_pkg::PSD_ST_PULLUP) ? psd_pkg::PSD_ST_PULLDN : psd_pkg::PSD_ST_DONE;
				end
				psd_pkg::PSD_ST_DONE:
					settle_cnt <= '0;
				default:
					state <= psd_pkg::PSD_ST_PULLUP;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			strap_pull_up_en <= '0;
			strap_pull_dn_en <= '0;
		end
		else
		begin
			strap_pull_up_en <= {psd_pkg::NUM_STRAPS{op_s && state == psd_pkg::PSD_ST_PULLUP}};
			strap_pull_dn_en <= {psd_pkg::NUM_STRAPS{op_s && state == psd_pkg::PSD_ST_PULLDN}};
		end
	end

	// video pin pull-down, enable pull-up: static weak pulls
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			video_pull_dn_en <= 1'b1;
			op_pull_up_en <= 1'b1;
		end
		else
		begin
			video_pull_dn_en <= 1'b1;
			op_pull_up_en <= 1'b1;
		end
	end

	// samples taken on the last settle cycle so the synchroniser delay has passed
	logic [psd_pkg::NUM_STRAPS-1:0] seen_up;
	logic [psd_pkg::NUM_STRAPS-1:0] seen_dn;
	psd_pkg::psd_level_t lvl [psd_pkg::NUM_STRAPS];

	for (genvar i = 0; i < psd_pkg::NUM_STRAPS; i++)
	begin : g_strap
		always_ff @(posedge sys_clk or posedge rst)
		begin
			if (rst)
			begin
				seen_up[i] <= 1'b0;
				seen_dn[i] <= 1'b0;
			end
			else if (phase_end && state == psd_pkg::PSD_ST_PULLUP && op_s)
				seen_up[i] <= strap_s[i];
			else if (phase_end && state == psd_pkg::PSD_ST_PULLDN && op_s)
				seen_dn[i] <= strap_s[i];
		end
		assign lvl[i] = resolve_level(seen_up[i], seen_dn[i]);
	end

	// two-level pins for addressing, taken at the end of pull-down sensing
	logic video_seen;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			video_seen <= 1'b0;
		else if (phase_end && state == psd_pkg::PSD_ST_PULLDN && op_s)
			video_seen <= video_s;
	end

	logic sensed;
	assign sensed = (state == psd_pkg::PSD_ST_DONE);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			config_valid <= 1'b0;
			strap_mode <= 1'b1;
		end
		else
		begin
			config_valid <= sensed && op_s;
			// mode select steers the configuration source
			strap_mode <= !mode_s;
		end
	end

	// address bits from the pins read as two levels
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			bus_addr_bits <= 2'h0;
		else if (sensed)
			bus_addr_bits <= {video_seen, seen_dn[psd_pkg::IDX_EQ]};
	end

	// strap decodes
	psd_pkg::psd_edge_t strap_edge;
	psd_pkg::psd_deemph_t strap_deemph;
	psd_pkg::psd_eq_t strap_eq;
	psd_pkg::psd_term_t strap_term;
	psd_pkg::psd_lane_t strap_lane;

	always_comb
	begin
		unique case (lvl[psd_pkg::IDX_EDGE])
			psd_pkg::PSD_LVL_HIGH: strap_edge = psd_pkg::PSD_EDGE_FAST;
			psd_pkg::PSD_LVL_LOW: strap_edge = psd_pkg::PSD_EDGE_SLOW5;
			default: strap_edge = psd_pkg::PSD_EDGE_SLOW10;
		endcase
		// de-emphasis strap, high passed on as reserved
		unique case (lvl[psd_pkg::IDX_DEEMPH])
			psd_pkg::PSD_LVL_LOW: strap_deemph = psd_pkg::PSD_DE_M2DB;
			psd_pkg::PSD_LVL_HIGH: strap_deemph = psd_pkg::PSD_DE_RSVD;
			default: strap_deemph = psd_pkg::PSD_DE_0DB;
		endcase
		unique case (lvl[psd_pkg::IDX_EQ])
			psd_pkg::PSD_LVL_LOW: strap_eq = psd_pkg::PSD_EQ_FIX7P5;
			psd_pkg::PSD_LVL_HIGH: strap_eq = psd_pkg::PSD_EQ_FIX14;
			default: strap_eq = psd_pkg::PSD_EQ_ADAPT;
		endcase
		unique case (lvl[psd_pkg::IDX_TERM])
			psd_pkg::PSD_LVL_HIGH: strap_term = psd_pkg::PSD_TERM_NONE;
			psd_pkg::PSD_LVL_LOW: strap_term = psd_pkg::PSD_TERM_75_150;
			default: strap_term = psd_pkg::PSD_TERM_AUTO;
		endcase
		unique case (lvl[psd_pkg::IDX_SWAP])
			psd_pkg::PSD_LVL_HIGH: strap_lane = psd_pkg::PSD_LANE_POLINV;
			psd_pkg::PSD_LVL_LOW: strap_lane = psd_pkg::PSD_LANE_SWAP;
			default: strap_lane = psd_pkg::PSD_LANE_NORMAL;
		endcase
	end

	// straps win in strap mode; bus writes only count in serial-control mode
	psd_pkg::psd_term_t req_term;
	assign req_term = mode_s ? bus_term : strap_term;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			edge_rate_sel <= psd_pkg::PSD_EDGE_FAST;
			deemph_sel <= psd_pkg::PSD_DE_0DB;
			eq_sel <= psd_pkg::PSD_EQ_ADAPT;
			lane_sel <= psd_pkg::PSD_LANE_NORMAL;
			video_dvi <= 1'b0;
		end
		else if (sensed)
		begin
			// bus edge rate in serial-control mode
			edge_rate_sel <= mode_s ? bus_edge_rate : strap_edge;
			deemph_sel <= mode_s ? bus_deemph : strap_deemph;
			eq_sel <= mode_s ? bus_eq : strap_eq;
			lane_sel <= mode_s ? bus_lane : strap_lane;
			video_dvi <= mode_s ? bus_video_dvi : video_seen;
		end
	end

	// automatic termination tracks the line rate continuously
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			term_sel <= psd_pkg::PSD_TERM_NONE;
			term_auto <= 1'b0;
		end
		else if (sensed)
		begin
			term_auto <= (req_term == psd_pkg::PSD_TERM_AUTO);
			term_sel <= (req_term == psd_pkg::PSD_TERM_AUTO) ? auto_term(line_rate) : req_term;
		end
	end

endmodule

// ---- test/psd_chk.sv ----
// Purpose: port-level checker for the strap decoder
// Assumes: single clock, async active-high reset
// Notes: attached by bind below
`timescale 1ns/1ps
module psd_chk(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic op_enable,
	input wire logic control_mode_sel,
	input wire logic [13:0] line_rate,
	input wire psd_pkg::psd_edge_t bus_edge_rate,
	input wire logic [4:0] strap_pull_up_en,
	input wire logic [4:0] strap_pull_dn_en,
	input wire logic power_down,
	input wire logic device_reset,
	input wire logic strap_mode,
	input wire logic config_valid,
	input wire psd_pkg::psd_edge_t edge_rate_sel,
	input wire psd_pkg::psd_eq_t eq_sel,
	input wire psd_pkg::psd_lane_t lane_sel,
	input wire psd_pkg::psd_term_t term_sel,
	input wire logic term_auto
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_pd_low;
		!op_enable [*5] |-> power_down;
	endproperty
	a_pd_low: assert property (p_pd_low) else $error("power_down low while disabled");
	property p_pd_high;
		op_enable [*5] |-> !power_down;
	endproperty
	a_pd_high: assert property (p_pd_high) else $error("power_down high while enabled");
	property p_cfg_pd;
		power_down |=> !config_valid;
	endproperty
	a_cfg_pd: assert property (p_cfg_pd) else $error("config valid in power down");
	property p_rst_fall;
		$fell(op_enable) |-> ##[2:4] device_reset;
	endproperty
	a_rst_fall: assert property (p_rst_fall) else $error("no reset after enable fall");
	property p_rst_pulse;
		device_reset |=> !device_reset;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("device_reset longer than one cycle");
	property p_mode;
		control_mode_sel [*5] |-> !strap_mode;
	endproperty
	a_mode: assert property (p_mode) else $error("strap_mode with serial select");
	property p_bus;
		(!strap_mode && config_valid) [*2] |-> edge_rate_sel == $past(bus_edge_rate);
	endproperty
	a_bus: assert property (p_bus) else $error("edge rate not from bus");
	property p_hold;
		config_valid && strap_mode && $past(config_valid && strap_mode)
			|-> $stable(edge_rate_sel) && $stable(eq_sel) && $stable(lane_sel);
	endproperty
	a_hold: assert property (p_hold) else $error("strap result changed");
	property p_pulls;
		config_valid |-> strap_pull_up_en == 5'h00 && strap_pull_dn_en == 5'h00;
	endproperty
	a_pulls: assert property (p_pulls) else $error("pulls on after sensing");
	property p_auto;
		term_auto && config_valid && $past(term_auto && config_valid) |-> term_sel ==
			($past(line_rate) > 14'd3400 ? psd_pkg::PSD_TERM_75_150 :
			$past(line_rate) >= 14'd2000 ? psd_pkg::PSD_TERM_150_300 : psd_pkg::PSD_TERM_NONE);
	endproperty
	a_auto: assert property (p_auto) else $error("auto termination wrong");
endmodule

bind psd_strap_decoder psd_chk u_chk(.sys_clk(sys_clk), .rst(rst), .op_enable(op_enable),
	.control_mode_sel(control_mode_sel), .line_rate(line_rate), .bus_edge_rate(bus_edge_rate),
	.strap_pull_up_en(strap_pull_up_en), .strap_pull_dn_en(strap_pull_dn_en), .power_down(power_down),
	.device_reset(device_reset), .strap_mode(strap_mode), .config_valid(config_valid),
	.edge_rate_sel(edge_rate_sel), .eq_sel(eq_sel), .lane_sel(lane_sel), .term_sel(term_sel),
	.term_auto(term_auto));

// ---- test/psd_strap_model.sv ----
// Purpose: board side of the strap pins
// Assumes: level code 0 low, 1 high, 2 open
// Notes: open pin with no pull wanders each cycle
`timescale 1ns/1ps
module psd_strap_model(
	input wire logic sys_clk,
	input wire logic [9:0] lvl,
	input wire logic [1:0] vid,
	input wire logic [4:0] pu,
	input wire logic [4:0] pd,
	input wire logic vpd,
	output logic [4:0] pin,
	output logic vpin
);
	logic tog = 1'b0;
	always @(posedge sys_clk) tog <= ~tog;
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			pin[i] = lvl[2*i+1] ? (pu[i] ? 1'b1 : pd[i] ? 1'b0 : tog) : lvl[2*i];
		vpin = vid[1] ? (vpd ? 1'b0 : tog) : vid[0];
	end
endmodule

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the strap decoder
// Assumes: settle time shortened to 4 cycles
// Notes: outputs sampled on the falling edge
`timescale 1ns/1ps
module testbench;
	localparam logic [1:0] LO = 2'h0;
	localparam logic [1:0] HI = 2'h1;
	localparam logic [1:0] OP = 2'h2;

	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic op_enable = 1'b1;
	logic control_mode_sel = 1'b0;
	// strap levels, two bits each: swap, term, eq, deemph, edge
	logic [9:0] strap_lvl = '0;
	logic [1:0] vid_lvl = LO;
	logic [13:0] line_rate = 14'h0;
	psd_pkg::psd_edge_t bus_edge_rate = psd_pkg::PSD_EDGE_SLOW10;
	psd_pkg::psd_deemph_t bus_deemph = psd_pkg::PSD_DE_RSVD;
	psd_pkg::psd_eq_t bus_eq = psd_pkg::PSD_EQ_FIX7P5;
	psd_pkg::psd_term_t bus_term = psd_pkg::PSD_TERM_150_300;
	psd_pkg::psd_lane_t bus_lane = psd_pkg::PSD_LANE_SWAP;
	logic bus_video_dvi = 1'b0;
	wire logic [4:0] strap_pin;
	wire logic video_pin;
	logic [4:0] pull_up;
	logic [4:0] pull_dn;
	logic video_pd;
	logic op_pu;
	logic power_down;
	logic device_reset;
	logic strap_mode;
	logic config_valid;
	psd_pkg::psd_edge_t edge_rate_sel;
	psd_pkg::psd_deemph_t deemph_sel;
	psd_pkg::psd_eq_t eq_sel;
	psd_pkg::psd_term_t term_sel;
	logic term_auto;
	psd_pkg::psd_lane_t lane_sel;
	logic video_dvi;
	logic [1:0] bus_addr_bits;
	int error_cnt = 0;
	int tests_run = 0;

	always #10 sys_clk = ~sys_clk;

	psd_strap_decoder #(.SETTLE_CYCLES(4)) u_dut(.sys_clk(sys_clk), .rst(rst), .op_enable(op_enable),
		.control_mode_sel(control_mode_sel), .edge_rate_strap(strap_pin[0]), .deemph_strap(strap_pin[1]),
		.equalizer_strap_addr1(strap_pin[2]), .termination_strap(strap_pin[3]),
		.lane_swap_polarity_strap(strap_pin[4]), .video_mode_strap_addr2(video_pin), .line_rate(line_rate),
		.bus_edge_rate(bus_edge_rate), .bus_deemph(bus_deemph), .bus_eq(bus_eq), .bus_term(bus_term),
		.bus_lane(bus_lane), .bus_video_dvi(bus_video_dvi), .strap_pull_up_en(pull_up),
		.strap_pull_dn_en(pull_dn), .video_pull_dn_en(video_pd), .op_pull_up_en(op_pu),
		.power_down(power_down), .device_reset(device_reset), .strap_mode(strap_mode),
		.config_valid(config_valid), .edge_rate_sel(edge_rate_sel), .deemph_sel(deemph_sel),
		.eq_sel(eq_sel), .term_sel(term_sel), .term_auto(term_auto), .lane_sel(lane_sel),
		.video_dvi(video_dvi), .bus_addr_bits(bus_addr_bits));

	psd_strap_model u_model(.sys_clk(sys_clk), .lvl(strap_lvl), .vid(vid_lvl), .pu(pull_up), .pd(pull_dn),
		.vpd(video_pd), .pin(strap_pin), .vpin(video_pin));

	task automatic print_verdict;
		$display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, exp);
		end
	endtask

	// pins settle while reset is held, as the board would
	task automatic do_reset;
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	task automatic wait_valid;
		int n;
		n = 0;
		while (config_valid !== 1'b1 && n < 40)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (config_valid !== 1'b1)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, config_valid, 1'b1);
			print_verdict();
		end
	endtask

	task automatic rate_step(input logic [13:0] rate, input psd_pkg::psd_term_t exp);
		@(posedge sys_clk);
		line_rate <= rate;
		repeat (2) @(negedge sys_clk);
		check(term_sel, exp);
	endtask

	task automatic t_strap_a;
		@(posedge sys_clk);
		op_enable <= 1'b1;
		control_mode_sel <= 1'b0;
		strap_lvl <= {OP, LO, OP, LO, HI};
		vid_lvl <= HI;
		do_reset();
		wait_valid();
		check(strap_mode, 1'b1);
		check(power_down, 1'b0);
		check({op_pu, video_pd}, 2'h3);
		check(edge_rate_sel, psd_pkg::PSD_EDGE_FAST);
		check(deemph_sel, psd_pkg::PSD_DE_M2DB);
		check(eq_sel, psd_pkg::PSD_EQ_ADAPT);
		check(term_sel, psd_pkg::PSD_TERM_75_150);
		check(term_auto, 1'b0);
		check(lane_sel, psd_pkg::PSD_LANE_NORMAL);
		check(video_dvi, 1'b1);
		check(bus_addr_bits, 2'h2);
		check({pull_up, pull_dn}, 10'h0);
		$display("t_strap_a done");
	endtask

	task automatic t_strap_b;
		@(posedge sys_clk);
		strap_lvl <= {HI, OP, HI, OP, LO};
		vid_lvl <= OP;
		line_rate <= 14'd3500;
		do_reset();
		wait_valid();
		check(edge_rate_sel, psd_pkg::PSD_EDGE_SLOW5);
		check(deemph_sel, psd_pkg::PSD_DE_0DB);
		check(eq_sel, psd_pkg::PSD_EQ_FIX14);
		check(term_auto, 1'b1);
		check(term_sel, psd_pkg::PSD_TERM_75_150);
		check(lane_sel, psd_pkg::PSD_LANE_POLINV);
		check(video_dvi, 1'b0);
		check(bus_addr_bits, 2'h1);
		rate_step(14'd3400, psd_pkg::PSD_TERM_150_300);
		rate_step(14'd2000, psd_pkg::PSD_TERM_150_300);
		rate_step(14'd1999, psd_pkg::PSD_TERM_NONE);
		rate_step(14'd3401, psd_pkg::PSD_TERM_75_150);
		$display("t_strap_b done");
	endtask

	task automatic t_strap_c;
		@(posedge sys_clk);
		strap_lvl <= {LO, HI, LO, HI, OP};
		vid_lvl <= LO;
		do_reset();
		wait_valid();
		check(edge_rate_sel, psd_pkg::PSD_EDGE_SLOW10);
		check(deemph_sel, psd_pkg::PSD_DE_RSVD);
		check(eq_sel, psd_pkg::PSD_EQ_FIX7P5);
		check(term_sel, psd_pkg::PSD_TERM_NONE);
		check(lane_sel, psd_pkg::PSD_LANE_SWAP);
		@(posedge sys_clk);
		strap_lvl <= {HI, LO, HI, LO, HI};
		repeat (10) @(negedge sys_clk);
		check(edge_rate_sel, psd_pkg::PSD_EDGE_SLOW10);
		check(eq_sel, psd_pkg::PSD_EQ_FIX7P5);
		$display("t_strap_c done");
	endtask

	task automatic t_serial;
		@(posedge sys_clk);
		control_mode_sel <= 1'b1;
		strap_lvl <= {OP, OP, HI, OP, HI};
		vid_lvl <= LO;
		bus_video_dvi <= 1'b1;
		do_reset();
		wait_valid();
		repeat (2) @(negedge sys_clk);
		check(strap_mode, 1'b0);
		check(edge_rate_sel, psd_pkg::PSD_EDGE_SLOW10);
		check(deemph_sel, psd_pkg::PSD_DE_RSVD);
		check(eq_sel, psd_pkg::PSD_EQ_FIX7P5);
		check(term_sel, psd_pkg::PSD_TERM_150_300);
		check(lane_sel, psd_pkg::PSD_LANE_SWAP);
		check(video_dvi, 1'b1);
		check(bus_addr_bits, 2'h1);
		@(posedge sys_clk);
		bus_edge_rate <= psd_pkg::PSD_EDGE_FAST;
		repeat (2) @(negedge sys_clk);
		check(edge_rate_sel, psd_pkg::PSD_EDGE_FAST);
		$display("t_serial done");
	endtask

	task automatic t_enable;
		int pulses;
		pulses = 0;
		@(posedge sys_clk);
		op_enable <= 1'b0;
		repeat (8)
		begin
			@(negedge sys_clk);
			if (device_reset === 1'b1)
				pulses++;
		end
		check(pulses, 1);
		check(power_down, 1'b1);
		check(config_valid, 1'b0);
		@(posedge sys_clk);
		op_enable <= 1'b1;
		wait_valid();
		check(power_down, 1'b0);
		check(bus_addr_bits, 2'h1);
		$display("t_enable done");
	endtask

	initial
	begin
		t_strap_a();
		t_strap_b();
		t_strap_c();
		t_serial();
		t_enable();
		print_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		print_verdict();
	end
endmodule
